//--- pkg/supply_regs_consts.svh
`ifndef SUPPLY_REGS_CONSTS_SVH
`define SUPPLY_REGS_CONSTS_SVH

// Register identifiers carried in the frame address
`define ADDR_SYSTEM_CONTROL 6'h02
`define ADDR_SLEEP_COMMAND 6'h03
`define ADDR_SYSTEM_STATE 6'h04
`define ADDR_POWER_STATUS 6'h05
`define ADDR_DEPLOY_CONFIG0 6'h06

// Sleep command key
`define SLEEP_KEY 16'h3C95

// system_control bit positions
`define CTL_RESTART_SEL 15
`define CTL_PULLDOWN 14
`define CTL_KEEP_SYNC 13
`define CTL_INPUT_TH 12
`define CTL_BATMON_HI 11
`define CTL_BATMON_LO 10
`define CTL_RES_BOOST_V 9
`define CTL_RES_CUR_HI 8
`define CTL_RES_CUR_LO 7
`define CTL_RES_BOOST_EN 6
`define CTL_SYNC_EN 5
`define CTL_POWER_OFF 4
`define CTL_SWITCH_LIM 2
`define CTL_SYNC_V 1
`define CTL_SATELLITE_VOLTAGE_SELECT 0

// system_control reset values
`define RST_KEEP_SYNC 1'h1
`define RST_BOOST_EN 1'h1
`define RST_ZERO_BIT 1'h0

// system_state field positions
`define STATE_PHASE_LO 8
`define STATE_POWER_LO 0

// deploy_config_channel0 field positions
`define DCR_TIME_LO 6
`define DCR_CUR_LO 4
`define DCR_EXP_LO 2
`define DCR_PD_CSR 0

// Operating phase and power-control codes
`define PHASE_INIT 3'h0
`define PHASE_DIAG 3'h1
`define PWR_ENERGY_RESERVE 3'h3
`define PWR_SHUTDOWN 3'h4

// Supply controller state codes
`define LOGIC_RAMPUP 2'h1
`define LOGIC_ON 2'h2
`define BOOST_CTL_ON 2'h1

`endif

//--- pkg/supply_regs_pkg.sv
package supply_regs_pkg;
	typedef struct packed {
		logic wr;
		logic [5:0] addr;
		logic [15:0] wdata;
	} spi_frame_t;

	typedef struct packed {
		logic wakeup_pin;
		logic battery_bad_status;
		logic battery_not_good_status;
		logic input_bad_status;
		logic input_not_good_status;
		logic sync_boost_low;
		logic satellite_buck_low;
		logic reserve_boost_low_status;
		logic logic_supply_undervoltage;
		logic logic_supply_overvoltage;
		logic input_above_fast_slope;
		logic sync_below_restart;
	} comparator_t;

	typedef struct packed {
		logic pulldown_leak_threshold_select;
		logic input_threshold_select;
		logic [1:0] battery_monitor_threshold_select;
		logic reserve_boost_voltage_select;
		logic [1:0] reserve_current_control;
		logic reserve_boost_enable;
		logic reserve_switch_limit_select;
		logic sync_boost_voltage_select;
		logic satellite_voltage_select;
	} supply_cfg_t;

	typedef struct packed {
		logic [5:0] deploy_time;
		logic [1:0] deploy_current;
		logic [1:0] expire_time;
		logic pd_current_csr;
	} deploy_cfg_t;

	typedef enum logic [1:0] {SB_NORMAL, SB_SUSPEND, SB_ARMED} sync_state_t;
endpackage : supply_regs_pkg

//--- rtl/level_sync.sv
`timescale 1ns/10ps
module level_sync #(
	parameter int WIDTH = 12
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : level_sync

//--- rtl/supply_control_status_regs.sv
// Operation
// R1: Select 0: sync boost off entering reserve, on when input exceeds fast-slope.
// R2: Select 1: restart sync boost when output falls below threshold after above.
// R3: Restart selection is ignored whenever keep-sync-boost-on is set.
// R4: Keep 0 disables sync boost entering reserve; writing 1 there restarts it.
// R5: Pull-down select picks squib pull-down and leak threshold; resets to 0.
// R6: Input threshold select chooses first or second input-good threshold.
// R7: Battery threshold field: 00/11 threshold 0, 01 threshold 1, 10 threshold 2.
// R8: Reserve boost voltage bit: 23 V or 33 V; loaded by safing reset or write; code reloads it on every reset.
// R9: Reserve current field: off, charge, discharge, off.
// R10: Reserve and sync boost enables request on at 1; reset to 1.
// R11: Power-off write of 1 acts only in power-mode shutdown.
// R12: Reserve switch limit bit changes only on power-on reset or write.
// R13: Sync boost voltage bit selects 12 V or 14.75 V.
// R14: Satellite voltage bit selects 7.2 V or 9 V.
// R15: Sleep key written to sleep register gives a non-latched shutdown request.
// R16: Operating phase reported in three bits; every reset forces init.
// R17: Power-control state reported in three bits; only power-on reset clears.
// R18: Low, undervoltage and overvoltage flags latch; power status read clears.
// R19: Wake-up, battery, input and reserve-low bits follow comparators live.
// R20: Logic supply active reads 1 in ramp-up or on; 0 after power-on reset.
// R21: Reserve boost running reads 1 only in boost on state.
// R22: Safing supply active mirrors safing supply enable; 0 on every reset.
// R23: Write to address not permitted in phase flags error next frame.
// R24: Writes to read-only registers are ignored, flags untouched.
`timescale 1ns/10ps
`include "supply_regs_consts.svh"
module supply_control_status_regs
	import supply_regs_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic wsm_rst,
	input wire logic ssm_rst,
	input wire logic frame_valid,
	input wire spi_frame_t frame,
	input wire logic [2:0] operating_phase_in,
	input wire logic [2:0] power_control_state_in,
	input wire logic [1:0] logic_supply_state,
	input wire logic [1:0] reserve_boost_state,
	input wire logic safing_supply_enable,
	input wire logic [5:0] supply_live,
	input wire comparator_t comparator_raw,
	output logic [19:0] read_data,
	output logic read_valid,
	output logic write_address_error,
	output supply_cfg_t supply_cfg,
	output deploy_cfg_t deploy_cfg,
	output logic sleep_request,
	output logic power_off_request,
	output logic sync_boost_on
);
	comparator_t cmp;
	logic any_rst;
	logic wr_frame;
	logic rd_frame;
	logic wr_ok;
	logic wr_ctl;
	logic wr_dcr;
	logic rd_power;
	logic [15:0] wd;
	logic sync_restart_comparator_select;
	logic keep_sync_boost_on;
	logic sync_boost_enable;
	logic power_off_bit;
	logic [2:0] operating_phase;
	logic [2:0] power_control_state;
	logic sync_boost_low_flag;
	logic satellite_buck_low_flag;
	logic logic_supply_undervoltage;
	logic logic_supply_overvoltage;
	logic logic_supply_active;
	logic reserve_boost_running;
	logic safing_supply_active;
	logic [5:0] live_state;
	logic in_reserve;
	logic in_reserve_d;
	logic reserve_entry;
	sync_state_t sb_state;
	sync_state_t next_sb_state;
	logic [19:0] next_read_data;

	// Writable addresses per operating phase
	function automatic logic write_permitted(input logic [5:0] addr,
			input logic [2:0] phase);
		case (addr)
			`ADDR_SYSTEM_CONTROL: write_permitted = 1'b1;
			`ADDR_SLEEP_COMMAND: write_permitted = 1'b1;
			`ADDR_DEPLOY_CONFIG0: write_permitted = (phase == `PHASE_DIAG);
			default: write_permitted = 1'b0;
		endcase
	endfunction : write_permitted

	level_sync #(
		.WIDTH($bits(comparator_t))
	) u_cmp_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.async_in(comparator_raw),
		.sync_out(cmp)
	);

	assign any_rst = sys_rst | wsm_rst | ssm_rst;
	assign wd = frame.wdata;
	assign wr_frame = frame_valid & frame.wr;
	assign rd_frame = frame_valid & ~frame.wr;
	assign wr_ok = wr_frame & write_permitted(frame.addr, operating_phase);
	assign wr_ctl = wr_ok & (frame.addr == `ADDR_SYSTEM_CONTROL);
	assign wr_dcr = wr_ok & (frame.addr == `ADDR_DEPLOY_CONFIG0);
	assign rd_power = rd_frame & (frame.addr == `ADDR_POWER_STATUS);

	// Fields touched by power-on reset only
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sync_restart_comparator_select <= `RST_ZERO_BIT;
			keep_sync_boost_on <= `RST_KEEP_SYNC;
		end else if (wr_ctl) begin
			sync_restart_comparator_select <= wd[`CTL_RESTART_SEL];
			keep_sync_boost_on <= wd[`CTL_KEEP_SYNC];
		end
	end

	// Fields reloaded by every reset, except the switch limit (power-on reset only)
	always_ff @(posedge mclk) begin
		if (any_rst) begin
			// Switch limit survives the soft resets
			if (sys_rst) begin
				supply_cfg.reserve_switch_limit_select <= `RST_ZERO_BIT; // R12
			end
			supply_cfg.pulldown_leak_threshold_select <= `RST_ZERO_BIT; // R5
			supply_cfg.input_threshold_select <= `RST_ZERO_BIT;
			supply_cfg.battery_monitor_threshold_select <= 2'h0;
			supply_cfg.reserve_boost_voltage_select <= `RST_ZERO_BIT; // R8
			supply_cfg.reserve_current_control <= 2'h0;
			supply_cfg.reserve_boost_enable <= `RST_BOOST_EN; // R10
			sync_boost_enable <= `RST_BOOST_EN; // R10
			supply_cfg.sync_boost_voltage_select <= `RST_ZERO_BIT; // R13
			supply_cfg.satellite_voltage_select <= `RST_ZERO_BIT; // R14
		end else if (wr_ctl) begin
			supply_cfg.reserve_switch_limit_select <= wd[`CTL_SWITCH_LIM]; // R12
			supply_cfg.pulldown_leak_threshold_select <= wd[`CTL_PULLDOWN]; // R5
			supply_cfg.input_threshold_select <= wd[`CTL_INPUT_TH]; // R6
			supply_cfg.battery_monitor_threshold_select <=
				wd[`CTL_BATMON_HI:`CTL_BATMON_LO]; // R7
			supply_cfg.reserve_boost_voltage_select <= wd[`CTL_RES_BOOST_V]; // R8
			supply_cfg.reserve_current_control <=
				wd[`CTL_RES_CUR_HI:`CTL_RES_CUR_LO]; // R9
			supply_cfg.reserve_boost_enable <= wd[`CTL_RES_BOOST_EN]; // R10
			sync_boost_enable <= wd[`CTL_SYNC_EN]; // R10
			supply_cfg.sync_boost_voltage_select <= wd[`CTL_SYNC_V]; // R13
			supply_cfg.satellite_voltage_select <= wd[`CTL_SATELLITE_VOLTAGE_SELECT]; // R14
		end
	end

	// Power-off request honoured only in shutdown
	always_ff @(posedge mclk) begin
		if (any_rst) begin
			power_off_bit <= 1'b0;
			power_off_request <= 1'b0;
		end else begin
			power_off_request <= wr_ctl & wd[`CTL_POWER_OFF] &
				(power_control_state == `PWR_SHUTDOWN); // R11
			if (wr_ctl && power_control_state == `PWR_SHUTDOWN) begin
				power_off_bit <= wd[`CTL_POWER_OFF]; // R11
			end
		end
	end

	// Sleep key: one-cycle request, nothing stored
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sleep_request <= 1'b0;
		end else begin
			sleep_request <= wr_ok & (frame.addr == `ADDR_SLEEP_COMMAND) &
				(wd == `SLEEP_KEY); // R15
		end
	end

	always_ff @(posedge mclk) begin
		if (any_rst) begin
			deploy_cfg <= '0;
		end else if (wr_dcr) begin
			deploy_cfg.deploy_time <= wd[`DCR_TIME_LO +: 6];
			deploy_cfg.deploy_current <= wd[`DCR_CUR_LO +: 2];
			deploy_cfg.expire_time <= wd[`DCR_EXP_LO +: 2];
			deploy_cfg.pd_current_csr <= wd[`DCR_PD_CSR];
		end
	end

	// Error shows in the frame after the offending write
	always_ff @(posedge mclk) begin
		if (any_rst) begin
			write_address_error <= 1'b0;
		end else if (frame_valid) begin
			write_address_error <= wr_frame & ~wr_ok; // R23
		end
	end

	// State reports
	always_ff @(posedge mclk) begin
		if (any_rst) begin
			operating_phase <= `PHASE_INIT; // R16
		end else begin
			operating_phase <= operating_phase_in; // R16
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			power_control_state <= 3'h0; // R17
		end else begin
			power_control_state <= power_control_state_in; // R17
		end
	end

	// Latched supply flags; a new event beats the read clear
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sync_boost_low_flag <= 1'b0;
			satellite_buck_low_flag <= 1'b0;
			logic_supply_undervoltage <= 1'b0;
			logic_supply_overvoltage <= 1'b0;
		end else begin
			sync_boost_low_flag <= cmp.sync_boost_low |
				(sync_boost_low_flag & ~rd_power); // R18 R24
			satellite_buck_low_flag <= cmp.satellite_buck_low |
				(satellite_buck_low_flag & ~rd_power); // R18
			logic_supply_undervoltage <= cmp.logic_supply_undervoltage |
				(logic_supply_undervoltage & ~rd_power); // R18
			logic_supply_overvoltage <= cmp.logic_supply_overvoltage |
				(logic_supply_overvoltage & ~rd_power); // R18
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			logic_supply_active <= 1'b0;
			reserve_boost_running <= 1'b0;
			live_state <= 6'h00;
		end else begin
			logic_supply_active <= (logic_supply_state == `LOGIC_RAMPUP) |
				(logic_supply_state == `LOGIC_ON); // R20
			reserve_boost_running <=
				(reserve_boost_state == `BOOST_CTL_ON); // R21
			live_state <= supply_live;
		end
	end

	always_ff @(posedge mclk) begin
		if (any_rst) begin
			safing_supply_active <= 1'b0; // R22
		end else begin
			safing_supply_active <= safing_supply_enable; // R22
		end
	end

	// Sync boost behaviour in energy reserve
	assign in_reserve = (power_control_state == `PWR_ENERGY_RESERVE);
	assign reserve_entry = in_reserve & ~in_reserve_d;

	always_comb begin
		next_sb_state = sb_state;
		case (sb_state)
			SB_NORMAL: begin
				if (reserve_entry && !keep_sync_boost_on) begin
					next_sb_state = SB_SUSPEND; // R4 R1 R2
				end
			end
			SB_SUSPEND: begin
				if (!in_reserve || keep_sync_boost_on) begin
					next_sb_state = SB_NORMAL; // R3 R4
				end else if (!sync_restart_comparator_select) begin
					if (cmp.input_above_fast_slope) begin
						next_sb_state = SB_NORMAL; // R1
					end
				end else if (!cmp.sync_below_restart) begin
					next_sb_state = SB_ARMED; // R2
				end
			end
			SB_ARMED: begin
				if (!in_reserve || keep_sync_boost_on) begin
					next_sb_state = SB_NORMAL; // R3
				end else if (!sync_restart_comparator_select) begin
					next_sb_state = SB_SUSPEND;
				end else if (cmp.sync_below_restart) begin
					next_sb_state = SB_NORMAL; // R2
				end
			end
			default: next_sb_state = SB_NORMAL;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sb_state <= SB_NORMAL;
			in_reserve_d <= 1'b0;
			sync_boost_on <= 1'b0;
		end else begin
			sb_state <= next_sb_state;
			in_reserve_d <= in_reserve;
			sync_boost_on <= sync_boost_enable &
				(next_sb_state == SB_NORMAL); // R1 R2 R4
		end
	end

	// Read path; flags show their value before the clear
	always_comb begin
		next_read_data = 20'h0_0000;
		case (frame.addr)
			`ADDR_SYSTEM_CONTROL: begin
				next_read_data = {4'h0, sync_restart_comparator_select,
					supply_cfg.pulldown_leak_threshold_select,
					keep_sync_boost_on, supply_cfg.input_threshold_select,
					supply_cfg.battery_monitor_threshold_select,
					supply_cfg.reserve_boost_voltage_select,
					supply_cfg.reserve_current_control,
					supply_cfg.reserve_boost_enable, sync_boost_enable,
					power_off_bit, 1'b0,
					supply_cfg.reserve_switch_limit_select,
					supply_cfg.sync_boost_voltage_select,
					supply_cfg.satellite_voltage_select};
			end
			`ADDR_SYSTEM_STATE: begin
				next_read_data[`STATE_PHASE_LO +: 3] = operating_phase; // R16
				next_read_data[`STATE_POWER_LO +: 3] =
					power_control_state; // R17
			end
			`ADDR_POWER_STATUS: begin
				next_read_data = {cmp.wakeup_pin, cmp.battery_bad_status,
					cmp.battery_not_good_status, cmp.input_bad_status,
					cmp.input_not_good_status, sync_boost_low_flag,
					satellite_buck_low_flag, cmp.reserve_boost_low_status,
					logic_supply_undervoltage, logic_supply_overvoltage,
					1'b0, reserve_boost_running, live_state,
					logic_supply_active, safing_supply_active}; // R19
			end
			`ADDR_DEPLOY_CONFIG0: begin
				next_read_data[11:0] = {deploy_cfg.deploy_time,
					deploy_cfg.deploy_current, deploy_cfg.expire_time,
					1'b0, deploy_cfg.pd_current_csr};
			end
			default: next_read_data = 20'h0_0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			read_data <= 20'h0_0000;
			read_valid <= 1'b0;
		end else begin
			read_valid <= rd_frame;
			if (rd_frame) begin
				read_data <= next_read_data;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence sleep_frame;
		wr_frame && frame.addr == `ADDR_SLEEP_COMMAND && wd == `SLEEP_KEY;
	endsequence

	sequence reserve_entered_unkept;
		sb_state == SB_NORMAL && reserve_entry && !keep_sync_boost_on;
	endsequence

	a_sleep_key_pulse: assert property (sleep_frame |=> sleep_request) // R15
		else $error("sleep key write gave no request");
	a_sleep_only_key: assert property (sleep_request |->
		$past(wr_frame && frame.addr == `ADDR_SLEEP_COMMAND &&
		wd == `SLEEP_KEY)) // R15
		else $error("sleep request without key write");
	a_power_off_gate: assert property (power_off_request |->
		$past(power_control_state) == `PWR_SHUTDOWN) // R11
		else $error("power off request outside shutdown");
	a_reserve_boost_off: assert property (reserve_entered_unkept
		##1 !ssm_rst && !wsm_rst |-> !sync_boost_on) // R4
		else $error("sync boost stayed on entering reserve");
	a_keep_restarts: assert property (sb_state == SB_SUSPEND &&
		keep_sync_boost_on |=> sb_state == SB_NORMAL) // R3
		else $error("keep bit did not restart sync boost");
	a_flag_set_wins: assert property (cmp.sync_boost_low |=>
		sync_boost_low_flag) // R18
		else $error("sync boost low event lost");
	a_flag_read_clear: assert property (rd_power && !cmp.satellite_buck_low
		|=> !satellite_buck_low_flag) // R18
		else $error("satellite flag not cleared by read");
	a_ro_write_kept: assert property (wr_frame &&
		frame.addr == `ADDR_POWER_STATUS && logic_supply_overvoltage
		|=> logic_supply_overvoltage) // R24
		else $error("write to status cleared a flag");
	a_wr_error_flag: assert property (wr_frame && !wr_ok && !any_rst
		|=> write_address_error) // R23
		else $error("bad write address not flagged");
	a_phase_reset: assert property (wsm_rst |=>
		operating_phase == `PHASE_INIT) // R16
		else $error("phase not reset");
	a_live_wakeup: assert property (rd_power |=>
		read_data[19] == $past(cmp.wakeup_pin)) // R19
		else $error("wake-up bit not live");
	a_logic_active: assert property (logic_supply_state == `LOGIC_ON
		|=> logic_supply_active) // R20
		else $error("logic supply active missing");
	a_boost_running: assert property (reserve_boost_state != `BOOST_CTL_ON
		|=> !reserve_boost_running) // R21
		else $error("boost running outside on state");
	a_safing_mirror: assert property (!ssm_rst && !wsm_rst |=>
		safing_supply_active == $past(safing_supply_enable)) // R22
		else $error("safing active does not mirror enable");
endmodule : supply_control_status_regs

//--- tb/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model
	import supply_regs_pkg::*;
(
	input wire logic mclk,
	output logic frame_valid,
	output spi_frame_t frame,
	input wire logic [19:0] read_data,
	input wire logic read_valid
);
	logic [19:0] last_read;
	logic last_valid;

	initial begin
		frame_valid = 1'b0;
		frame = '0;
		last_read = '0;
		last_valid = 1'b0;
	end

	// One frame per call, launched just after an edge, answer taken next edge
	task automatic xfer(input logic wr, input logic [5:0] addr,
		input logic [15:0] data);
		@(posedge mclk);
		#1;
		frame_valid = 1'b1;
		frame = '{wr: wr, addr: addr, wdata: data};
		@(posedge mclk);
		#1;
		frame_valid = 1'b0;
		// Released frame lines are inverted once so no stale value is trusted
		frame = ~frame;
		last_valid = read_valid;
		last_read = read_data;
	endtask : xfer
endmodule : spi_host_model

//--- tb/tb_supply_control_status_regs.sv
`timescale 1ns/10ps
`include "supply_regs_consts.svh"
module tb_supply_control_status_regs
	import supply_regs_pkg::*;
	;
	logic mclk, sys_rst, wsm_rst, ssm_rst, frame_valid, sse;
	spi_frame_t frame;
	logic [2:0] phase_in, pwr_in;
	logic [1:0] lss, rbs;
	logic [5:0] live;
	comparator_t cmp;
	logic [19:0] read_data;
	logic read_valid, write_address_error, sleep_request;
	logic power_off_request, sync_boost_on;
	supply_cfg_t supply_cfg;
	deploy_cfg_t deploy_cfg;
	int n_fail, num_checks;

	supply_control_status_regs DUT (.mclk(mclk), .sys_rst(sys_rst),
		.wsm_rst(wsm_rst), .ssm_rst(ssm_rst), .frame_valid(frame_valid),
		.frame(frame), .operating_phase_in(phase_in),
		.power_control_state_in(pwr_in), .logic_supply_state(lss),
		.reserve_boost_state(rbs), .safing_supply_enable(sse),
		.supply_live(live), .comparator_raw(cmp), .read_data(read_data),
		.read_valid(read_valid), .write_address_error(write_address_error),
		.supply_cfg(supply_cfg), .deploy_cfg(deploy_cfg),
		.sleep_request(sleep_request), .power_off_request(power_off_request),
		.sync_boost_on(sync_boost_on));

	spi_host_model u_host (.mclk(mclk), .frame_valid(frame_valid),
		.frame(frame), .read_data(read_data), .read_valid(read_valid));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic conclude();
		if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude

	task automatic chk(input string name, input logic [19:0] exp,
		input logic [19:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		u_host.xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [19:0] exp,
		input string name);
		u_host.xfer(1'b0, a, 16'h0000);
		chk("read_valid", 20'h0_0001, 20'(u_host.last_valid));
		chk(name, exp, u_host.last_read);
	endtask : rd

	task automatic wait_boost(input logic exp);
		int i;
		for (i = 0; i < 10 && sync_boost_on !== exp; i++) tick(1);
		chk("sync_boost_on", 20'(exp), 20'(sync_boost_on));
		if (sync_boost_on !== exp) conclude();
	endtask : wait_boost

	task automatic t_reset();
		chk("supply_cfg", 20'h0_0008, 20'(supply_cfg));
		rd(`ADDR_SYSTEM_CONTROL, 20'h0_2060, "ctl");
		chk("sync_boost_on", 20'h0_0001, 20'(sync_boost_on));
	endtask : t_reset

	task automatic t_cfg();
		wr(`ADDR_SYSTEM_CONTROL, 16'hFFFF);
		chk("power_off_request", 20'h0, 20'(power_off_request));
		chk("supply_cfg", 20'h0_07FF, 20'(supply_cfg));
		rd(`ADDR_SYSTEM_CONTROL, 20'h0_FFE7, "ctl");
		for (int c = 0; c < 4; c++) begin
			wr(`ADDR_SYSTEM_CONTROL, 16'((c << 10) | (c << 7)));
			chk("batmon", 20'(c),
				20'(supply_cfg.battery_monitor_threshold_select));
			chk("res_cur", 20'(c), 20'(supply_cfg.reserve_current_control));
		end
		for (int k = 0; k < 2; k++) begin
			wr(`ADDR_SYSTEM_CONTROL, 16'hFFFF);
			if (k == 0) ssm_rst = 1'b1;
			else wsm_rst = 1'b1;
			tick(1);
			ssm_rst = 1'b0;
			wsm_rst = 1'b0;
			rd(`ADDR_SYSTEM_CONTROL, 20'h0_A064, "ctl soft");
		end
		sys_rst = 1'b1;
		tick(2);
		sys_rst = 1'b0;
		rd(`ADDR_SYSTEM_CONTROL, 20'h0_2060, "ctl por");
	endtask : t_cfg

	task automatic t_power_off();
		pwr_in = `PWR_SHUTDOWN;
		tick(2);
		wr(`ADDR_SYSTEM_CONTROL, 16'h0010);
		chk("power_off_request", 20'h1, 20'(power_off_request));
		tick(1);
		chk("power_off_request", 20'h0, 20'(power_off_request));
		pwr_in = 3'h2;
	endtask : t_power_off

	task automatic t_sleep();
		wr(`ADDR_SLEEP_COMMAND, `SLEEP_KEY);
		chk("sleep_request", 20'h1, 20'(sleep_request));
		tick(1);
		chk("sleep_request", 20'h0, 20'(sleep_request));
		wr(`ADDR_SLEEP_COMMAND, 16'h3C94);
		chk("sleep_request", 20'h0, 20'(sleep_request));
		chk("wr_err", 20'h0, 20'(write_address_error));
	endtask : t_sleep

	task automatic t_status();
		phase_in = 3'h4;
		lss = 2'h2;
		rbs = 2'h1;
		sse = 1'b1;
		live = 6'h2A;
		cmp.wakeup_pin = 1'b1;
		cmp.sync_boost_low = 1'b1;
		cmp.satellite_buck_low = 1'b1;
		cmp.logic_supply_overvoltage = 1'b1;
		tick(4);
		cmp.sync_boost_low = 1'b0;
		cmp.satellite_buck_low = 1'b0;
		cmp.logic_supply_overvoltage = 1'b0;
		tick(4);
		rd(`ADDR_SYSTEM_STATE, 20'h0_0402, "state");
		wr(`ADDR_POWER_STATUS, 16'hFFFF);
		chk("wr_err", 20'h1, 20'(write_address_error));
		rd(`ADDR_POWER_STATUS, 20'h8_65AB, "status");
		rd(`ADDR_POWER_STATUS, 20'h8_01AB, "status");
		lss = 2'h3;
		rbs = 2'h2;
		sse = 1'b0;
		cmp.wakeup_pin = 1'b0;
		tick(4);
		rd(`ADDR_POWER_STATUS, 20'h0_00A8, "status");
	endtask : t_status

	task automatic t_errors();
		phase_in = `PHASE_INIT;
		wr(6'h3F, 16'hFFFF);
		chk("wr_err", 20'h1, 20'(write_address_error));
		rd(6'h3F, 20'h0, "unmapped");
		wr(`ADDR_DEPLOY_CONFIG0, 16'h0FFD);
		chk("wr_err", 20'h1, 20'(write_address_error));
		chk("deploy_cfg", 20'h0, 20'(deploy_cfg));
		phase_in = `PHASE_DIAG;
		tick(2);
		wr(`ADDR_DEPLOY_CONFIG0, 16'h0FFD);
		chk("wr_err", 20'h0, 20'(write_address_error));
		chk("deploy_cfg", 20'h0_07FF, 20'(deploy_cfg));
		rd(`ADDR_DEPLOY_CONFIG0, 20'h0_0FFD, "deploy");
	endtask : t_errors

	task automatic t_boost();
		wr(`ADDR_SYSTEM_CONTROL, 16'h0060);
		tick(2);
		wait_boost(1'b1);
		pwr_in = `PWR_ENERGY_RESERVE;
		wait_boost(1'b0);
		cmp.input_above_fast_slope = 1'b1;
		wait_boost(1'b1);
		pwr_in = 3'h2;
		cmp.input_above_fast_slope = 1'b0;
		tick(2);
		pwr_in = `PWR_ENERGY_RESERVE;
		wait_boost(1'b0);
		wr(`ADDR_SYSTEM_CONTROL, 16'h2060);
		wait_boost(1'b1);
		pwr_in = 3'h2;
		wr(`ADDR_SYSTEM_CONTROL, 16'h8060);
		cmp.sync_below_restart = 1'b1;
		tick(2);
		pwr_in = `PWR_ENERGY_RESERVE;
		wait_boost(1'b0);
		cmp.sync_below_restart = 1'b0;
		tick(6);
		chk("sync_boost_on", 20'h0, 20'(sync_boost_on));
		cmp.sync_below_restart = 1'b1;
		wait_boost(1'b1);
		pwr_in = 3'h2;
		wr(`ADDR_SYSTEM_CONTROL, 16'hA060);
		tick(2);
		pwr_in = `PWR_ENERGY_RESERVE;
		tick(4);
		chk("sync_boost_on", 20'h1, 20'(sync_boost_on));
	endtask : t_boost

	initial begin
		n_fail = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		wsm_rst = 1'b0;
		ssm_rst = 1'b0;
		phase_in = `PHASE_INIT;
		pwr_in = 3'h0;
		lss = 2'h0;
		rbs = 2'h0;
		sse = 1'b0;
		live = 6'h00;
		cmp = '0;
		tick(2);
		sys_rst = 1'b0;
		t_reset();
		t_cfg();
		t_power_off();
		t_sleep();
		t_status();
		t_errors();
		t_boost();
		conclude();
	end
endmodule : tb_supply_control_status_regs
